// ==== shared/mmc_pkg.sv ====
// Package with register layout, encodings and timing counts for the mode control block.
`default_nettype none
package mmc_pkg;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [3:0] ADDR_MODE_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_FILTER_SETUP = 4'h1;
	localparam logic [3:0] ADDR_LINK_STATUS = 4'h2;
	localparam logic [31:0] MODE_CONTROL_RESET = 32'h0000_0040;
	localparam logic [31:0] MODE_WRITE_MASK = 32'h0000_3EEA;
	localparam int BIT_TX_RUN = 13;
	localparam int BIT_FORCE_COLLISION = 12;
	localparam int BIT_LOOPBACK_HI = 11;
	localparam int BIT_LOOPBACK_LO = 10;
	localparam int BIT_FULL_DUPLEX = 9;
	localparam int BIT_RESERVED_ZERO = 8;
	localparam int BIT_PASS_ALL_MULTICAST = 7;
	localparam int BIT_ACCEPT_ALL = 6;
	localparam int BIT_BACKOFF_HOLD = 5;
	localparam int BIT_INVERSE_FILTER = 4;
	localparam int BIT_PASS_BAD = 3;
	localparam int BIT_IMPERFECT_ALL = 2;
	localparam int BIT_RX_RUN = 1;
	localparam int BIT_HASH_PERFECT = 0;
	// Filter setup register fields, loaded by the setup-frame engine.
	localparam int SETUP_BIT_HASH_PERFECT = 0;
	localparam int SETUP_BIT_IMPERFECT_ALL = 1;
	localparam int SETUP_BIT_INVERSE = 2;
	// ****************************************************************
	// Loopback encoding
	// ****************************************************************
	localparam logic [1:0] LOOP_NORMAL = 2'h0;
	localparam logic [1:0] LOOP_INTERNAL = 2'h1;
	localparam logic [1:0] LOOP_EXTERNAL = 2'h2;
	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int ATTEMPT_LIMIT = 16;
	localparam int CLOCK_MHZ = 50;
	localparam int GAP_10M_NS = 9600;
	localparam int GAP_100M_NS = 960;
	localparam int CLOCK_PERIOD_NS = 1000 / CLOCK_MHZ;
	localparam logic [9:0] GAP_10M_CYCLES =
		10'((GAP_10M_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
	localparam logic [9:0] GAP_100M_CYCLES =
		10'((GAP_100M_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
	typedef enum logic [2:0] {
		MMC_TX_IDLE = 3'b001,
		MMC_TX_WAIT = 3'b010,
		MMC_TX_SEND = 3'b100
	} mmc_tx_state_t;
	function automatic logic mmc_is_internal(input logic [1:0] sel);
		return sel == LOOP_INTERNAL;
	endfunction : mmc_is_internal
endpackage : mmc_pkg
`default_nettype wire

// ==== rtl/mmc_addr_filter.sv ====
// Receive address filter decision for the mode control block.
`timescale 1ns/1ps
`default_nettype none
module mmc_addr_filter (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic frameDone,
	input wire logic [47:0] destAddr,
	input wire logic frameBad,
	input wire logic perfectHit,
	input wire logic hashHit,
	input wire logic passAllMulticast,
	input wire logic acceptAllFrames,
	input wire logic passBadFrames,
	input wire logic hashPerfectSelect,
	input wire logic imperfectAllFilter,
	input wire logic inverseFilter,
	output logic acceptValid,
	output logic acceptFrame
);
	logic isMulticast;
	logic addrPass;
	logic physPass;
	logic multiPass;
	// The first transmitted bit of the destination is bit 0 of the first octet.
	assign isMulticast = destAddr[40];
	always_comb begin
		if (hashPerfectSelect) begin
			multiPass = hashHit;
			physPass = imperfectAllFilter ? hashHit : perfectHit;
		end else begin
			multiPass = perfectHit ^ inverseFilter;
			physPass = perfectHit ^ inverseFilter;
		end
		if (passAllMulticast && isMulticast) begin
			multiPass = 1'b1;
		end
		addrPass = acceptAllFrames || (isMulticast ? multiPass : physPass);
	end
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			acceptValid <= 1'b0;
			acceptFrame <= 1'b0;
		end else begin
			acceptValid <= frameDone;
			acceptFrame <= frameDone && addrPass && (!frameBad || passBadFrames);
		end
	end
endmodule : mmc_addr_filter
`default_nettype wire

// ==== rtl/mmc_backoff.sv ====
// Backoff counter with optional hold on carrier and post-carrier gap.
`timescale 1ns/1ps
`default_nettype none
module mmc_backoff (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic load,
	input wire logic [9:0] slots,
	input wire logic carrier,
	input wire logic holdOnCarrier,
	input wire logic rate100,
	output logic done
);
	logic [9:0] count;
	logic [9:0] gap;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			count <= 10'h000;
		end else if (load) begin
			count <= slots;
		end else if (count != 10'h000 && !(holdOnCarrier && carrier)) begin
			count <= count - 10'h001;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			gap <= 10'h000;
		end else if (holdOnCarrier && carrier) begin
			gap <= rate100 ? mmc_pkg::GAP_100M_CYCLES : mmc_pkg::GAP_10M_CYCLES;
		end else if (gap != 10'h000) begin
			gap <= gap - 10'h001;
		end
	end
	assign done = !load && count == 10'h000 && gap == 10'h000 && !(holdOnCarrier && carrier);
endmodule : mmc_backoff
`default_nettype wire

// ==== rtl/mmc_mode_control.sv ====
// Operating-mode register bits 13 to 0 and the transmit control they steer.
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Force-collision makes every attempt of the next transmit collide, sixteen attempts, excessive collision reported.
// - Force-collision acts only in internal loopback.
// - Bits 11:10 select the loopback mode for both paths.
// - Loopback codes: 00 normal, 01 internal, 10 external.
// - Full-duplex lets transmit and receive run together.
// - Full-duplex disables heartbeat check; internal loopback not used then.
// - Pass-all-multicast accepts every multicast destination.
// - Accept-all receives every valid frame.
// - Accept-all is set after reset.
// - Backoff-hold pauses the backoff counter during carrier.
// - With backoff-hold, wait 9.6 us or 0.96 us after carrier.
// - Without backoff-hold the backoff counter ignores carrier.
// - Read-only bit 4 shows inverse filtering, meaningful in perfect mode.
// - Pass-bad-frames accepts bad frames that pass address filtering.
// - Read-only bit 2 shows hash filtering of all addresses.
// - Hash/perfect clear gives perfect filtering; set hashes multicast.
module mmc_mode_control (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [3:0] regAddr,
	input wire logic [31:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regReadData,
	input wire logic rate100,
	input wire logic carrierSense,
	input wire logic collisionIn,
	input wire logic txRequest,
	input wire logic txEndOk,
	input wire logic [9:0] backoffSlots,
	input wire logic rxActive,
	input wire logic rxFrameDone,
	input wire logic [47:0] rxDestAddr,
	input wire logic rxFrameBad,
	input wire logic perfectHit,
	input wire logic hashHit,
	output logic [1:0] loopbackSelect,
	output logic fullDuplex,
	output logic heartbeatCheckEnable,
	output logic txEnable,
	output logic txForcedCollision,
	output logic txDone,
	output logic txExcessiveCollision,
	output logic rxAcceptValid,
	output logic rxAccept
);
	// ****************************************************************
	// Register storage
	// ****************************************************************
	logic [31:0] modeControl;
	logic [2:0] filterSetup;
	logic forceCollisionArmed;
	logic [4:0] attempts;
	mmc_pkg::mmc_tx_state_t txState;
	logic backoffLoad;
	logic backoffDone;
	logic collisionSeen;
	logic forceActive;
	logic acceptValidInt;
	logic acceptInt;
	logic [31:0] modeReadView;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			modeControl <= mmc_pkg::MODE_CONTROL_RESET;
		end else if (regWrite && regAddr == mmc_pkg::ADDR_MODE_CONTROL) begin
			// Bit 8 and the read-only filter bits are not stored from software.
			modeControl <= regWriteData & mmc_pkg::MODE_WRITE_MASK;
		end
	end

	// Filter mode bits come from the setup-frame engine, seen here as a register.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			filterSetup <= 3'h0;
		end else if (regWrite && regAddr == mmc_pkg::ADDR_FILTER_SETUP) begin
			filterSetup <= regWriteData[2:0];
		end
	end

	always_comb begin
		modeReadView = modeControl;
		modeReadView[mmc_pkg::BIT_RESERVED_ZERO] = 1'b0;
		modeReadView[mmc_pkg::BIT_INVERSE_FILTER] = filterSetup[mmc_pkg::SETUP_BIT_INVERSE];
		modeReadView[mmc_pkg::BIT_IMPERFECT_ALL] =
			filterSetup[mmc_pkg::SETUP_BIT_IMPERFECT_ALL];
		modeReadView[mmc_pkg::BIT_HASH_PERFECT] = filterSetup[mmc_pkg::SETUP_BIT_HASH_PERFECT];
	end

	// ****************************************************************
	// Register read port
	// ****************************************************************
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			regReadData <= 32'h0000_0000;
		end else if (regRead) begin
			unique case (regAddr)
				mmc_pkg::ADDR_MODE_CONTROL: regReadData <= modeReadView;
				mmc_pkg::ADDR_FILTER_SETUP: regReadData <= {29'h0000_0000, filterSetup};
				mmc_pkg::ADDR_LINK_STATUS: regReadData <= {27'h0000_000, txState,
					forceCollisionArmed, txExcessiveCollision};
				default: regReadData <= 32'h0000_0000;
			endcase
		end else begin
			regReadData <= 32'h0000_0000;
		end
	end

	// ****************************************************************
	// Mode outputs
	// ****************************************************************
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			loopbackSelect <= mmc_pkg::LOOP_NORMAL;
			fullDuplex <= 1'b0;
			heartbeatCheckEnable <= 1'b1;
		end else begin
			loopbackSelect <= modeControl[mmc_pkg::BIT_LOOPBACK_HI:mmc_pkg::BIT_LOOPBACK_LO];
			fullDuplex <= modeControl[mmc_pkg::BIT_FULL_DUPLEX];
			heartbeatCheckEnable <= !modeControl[mmc_pkg::BIT_FULL_DUPLEX];
		end
	end

	// ****************************************************************
	// Forced collision and transmit attempts
	// ****************************************************************
	assign forceActive = forceCollisionArmed &&
		mmc_pkg::mmc_is_internal(modeControl[mmc_pkg::BIT_LOOPBACK_HI:mmc_pkg::BIT_LOOPBACK_LO]);
	// In half duplex a receive in progress counts as a collision during transmit; full duplex ignores it.
	assign collisionSeen = collisionIn || forceActive ||
		(!modeControl[mmc_pkg::BIT_FULL_DUPLEX] && rxActive);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			forceCollisionArmed <= 1'b0;
		end else if (regWrite && regAddr == mmc_pkg::ADDR_MODE_CONTROL) begin
			forceCollisionArmed <= regWriteData[mmc_pkg::BIT_FORCE_COLLISION];
		end else if (txState == mmc_pkg::MMC_TX_IDLE && txDone) begin
			forceCollisionArmed <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			txState <= mmc_pkg::MMC_TX_IDLE;
			attempts <= 5'h00;
			txEnable <= 1'b0;
			txForcedCollision <= 1'b0;
			txDone <= 1'b0;
			txExcessiveCollision <= 1'b0;
		end else begin
			txDone <= 1'b0;
			txForcedCollision <= 1'b0;
			unique case (txState)
				mmc_pkg::MMC_TX_IDLE: begin
					if (txRequest) begin
						attempts <= 5'h00;
						txExcessiveCollision <= 1'b0;
						txState <= mmc_pkg::MMC_TX_WAIT;
					end
				end
				mmc_pkg::MMC_TX_WAIT: begin
					if (backoffDone) begin
						txEnable <= 1'b1;
						txState <= mmc_pkg::MMC_TX_SEND;
					end
				end
				mmc_pkg::MMC_TX_SEND: begin
					if (collisionSeen) begin
						txEnable <= 1'b0;
						txForcedCollision <= forceActive;
						attempts <= attempts + 5'h01;
						if (attempts == 5'(mmc_pkg::ATTEMPT_LIMIT - 1)) begin
							txExcessiveCollision <= 1'b1;
							txDone <= 1'b1;
							txState <= mmc_pkg::MMC_TX_IDLE;
						end else begin
							txState <= mmc_pkg::MMC_TX_WAIT;
						end
					end else if (txEndOk) begin
						txEnable <= 1'b0;
						txDone <= 1'b1;
						txState <= mmc_pkg::MMC_TX_IDLE;
					end
				end
			endcase
		end
	end

	assign backoffLoad = txState == mmc_pkg::MMC_TX_SEND && collisionSeen;

	mmc_backoff u_backoff (
		.sys_clk(sys_clk),
		.reset(reset),
		.load(backoffLoad),
		.slots(backoffSlots),
		.carrier(carrierSense),
		.holdOnCarrier(modeControl[mmc_pkg::BIT_BACKOFF_HOLD]),
		.rate100(rate100),
		.done(backoffDone)
	);

	// ****************************************************************
	// Receive address filter
	// ****************************************************************
	mmc_addr_filter u_filter (
		.sys_clk(sys_clk),
		.reset(reset),
		.frameDone(rxFrameDone),
		.destAddr(rxDestAddr),
		.frameBad(rxFrameBad),
		.perfectHit(perfectHit),
		.hashHit(hashHit),
		.passAllMulticast(modeControl[mmc_pkg::BIT_PASS_ALL_MULTICAST]),
		.acceptAllFrames(modeControl[mmc_pkg::BIT_ACCEPT_ALL]),
		.passBadFrames(modeControl[mmc_pkg::BIT_PASS_BAD]),
		.hashPerfectSelect(filterSetup[mmc_pkg::SETUP_BIT_HASH_PERFECT]),
		.imperfectAllFilter(filterSetup[mmc_pkg::SETUP_BIT_IMPERFECT_ALL]),
		.inverseFilter(filterSetup[mmc_pkg::SETUP_BIT_INVERSE]),
		.acceptValid(acceptValidInt),
		.acceptFrame(acceptInt)
	);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rxAcceptValid <= 1'b0;
			rxAccept <= 1'b0;
		end else begin
			rxAcceptValid <= acceptValidInt;
			rxAccept <= acceptInt;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_reset_accept_all;
		@(posedge sys_clk) $fell(reset) |-> modeControl[mmc_pkg::BIT_ACCEPT_ALL];
	endproperty
	a_reset_accept_all: assert property (p_reset_accept_all) else $error("accept-all clear after reset");

	property p_excessive;
		@(posedge sys_clk) disable iff (reset) txExcessiveCollision && !$past(txExcessiveCollision)
			|-> $past(attempts) == 5'(mmc_pkg::ATTEMPT_LIMIT - 1) && txDone;
	endproperty
	a_excessive: assert property (p_excessive) else $error("excessive collision count wrong");

	property p_force_internal;
		@(posedge sys_clk) disable iff (reset) txForcedCollision |->
			$past(loopbackSelect) == mmc_pkg::LOOP_INTERNAL ||
			$past(modeControl[mmc_pkg::BIT_LOOPBACK_HI:mmc_pkg::BIT_LOOPBACK_LO]) ==
			mmc_pkg::LOOP_INTERNAL;
	endproperty
	a_force_internal: assert property (p_force_internal) else $error("forced collision outside loop");

	property p_loop_follow;
		@(posedge sys_clk) disable iff (reset) ##1
			loopbackSelect == $past(modeControl[mmc_pkg::BIT_LOOPBACK_HI:mmc_pkg::BIT_LOOPBACK_LO]);
	endproperty
	a_loop_follow: assert property (p_loop_follow) else $error("loopback select stale");

	property p_heartbeat;
		@(posedge sys_clk) disable iff (reset) fullDuplex |-> !heartbeatCheckEnable;
	endproperty
	a_heartbeat: assert property (p_heartbeat) else $error("heartbeat on in full duplex");

	property p_hold;
		@(posedge sys_clk) disable iff (reset)
			modeControl[mmc_pkg::BIT_BACKOFF_HOLD] && carrierSense && txState == mmc_pkg::MMC_TX_WAIT
			|=> !txEnable;
	endproperty
	a_hold: assert property (p_hold) else $error("transmit started during carrier");

	property p_accept_all;
		@(posedge sys_clk) disable iff (reset)
			rxFrameDone && modeControl[mmc_pkg::BIT_ACCEPT_ALL] &&
			(!rxFrameBad || modeControl[mmc_pkg::BIT_PASS_BAD]) |-> ##2 rxAccept;
	endproperty
	a_accept_all: assert property (p_accept_all) else $error("frame dropped in accept-all");

	property p_bad_drop;
		@(posedge sys_clk) disable iff (reset)
			rxFrameDone && rxFrameBad && !modeControl[mmc_pkg::BIT_PASS_BAD] |-> ##2 !rxAccept;
	endproperty
	a_bad_drop: assert property (p_bad_drop) else $error("bad frame passed");
endmodule : mmc_mode_control
`default_nettype wire

// ==== tb/mmc_mode_control_tb.sv ====
// Self-checking testbench for the mode control block.
`timescale 1ns/1ps
`default_nettype none
module mmc_mode_control_tb;
	logic sys_clk = 1'h0;
	logic reset = 1'h1;
	logic [3:0] regAddr = 4'h0;
	logic [31:0] regWriteData = 32'h0;
	logic regWrite = 1'h0;
	logic regRead = 1'h0;
	logic [31:0] regReadData;
	logic rate100 = 1'h0;
	logic carrierSense = 1'h0;
	logic collisionIn = 1'h0;
	logic txRequest = 1'h0;
	logic txEndOk = 1'h0;
	logic [9:0] backoffSlots = 10'h3;
	logic rxActive = 1'h0;
	logic rxFrameDone = 1'h0;
	logic [47:0] rxDestAddr = 48'h0;
	logic rxFrameBad = 1'h0;
	logic perfectHit = 1'h0;
	logic hashHit = 1'h0;
	logic [1:0] loopbackSelect;
	logic fullDuplex, heartbeatCheckEnable, txEnable, txForcedCollision, txDone;
	logic txExcessiveCollision, rxAcceptValid, rxAccept;
	int err_total = 0;
	int checks = 0;
	int nForced = 0;

	mmc_mode_control i_mmc_mode_control (
		.sys_clk(sys_clk), .reset(reset), .regAddr(regAddr), .regWriteData(regWriteData),
		.regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
		.rate100(rate100), .carrierSense(carrierSense), .collisionIn(collisionIn),
		.txRequest(txRequest), .txEndOk(txEndOk), .backoffSlots(backoffSlots),
		.rxActive(rxActive), .rxFrameDone(rxFrameDone), .rxDestAddr(rxDestAddr),
		.rxFrameBad(rxFrameBad), .perfectHit(perfectHit), .hashHit(hashHit),
		.loopbackSelect(loopbackSelect), .fullDuplex(fullDuplex),
		.heartbeatCheckEnable(heartbeatCheckEnable), .txEnable(txEnable),
		.txForcedCollision(txForcedCollision), .txDone(txDone),
		.txExcessiveCollision(txExcessiveCollision), .rxAcceptValid(rxAcceptValid),
		.rxAccept(rxAccept)
	);

	always #10 sys_clk = ~sys_clk;

	// Forced collisions are one-cycle pulses, so they are counted on every edge.
	always @(posedge sys_clk) begin
		if (txForcedCollision === 1'h1) begin
			nForced++;
		end
	end

	// ****************************************************************
	// Checking and bus tasks
	// ****************************************************************
	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit

	task automatic chk_cnt(input int got, input int lo, input int hi);
		checks++;
		if (got < lo || got > hi) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask : chk_cnt

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWriteData <= d;
		regWrite <= 1'h1;
		@(posedge sys_clk);
		regWrite <= 1'h0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so sample there.
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regRead <= 1'h1;
		@(posedge sys_clk);
		regRead <= 1'h0;
		#1;
		d = regReadData;
	endtask : rd

	function automatic logic [31:0] exp_mode(input logic [31:0] w, input logic [2:0] s);
		logic [31:0] e;
		e = w & mmc_pkg::MODE_WRITE_MASK;
		e[mmc_pkg::BIT_HASH_PERFECT] = s[mmc_pkg::SETUP_BIT_HASH_PERFECT];
		e[mmc_pkg::BIT_IMPERFECT_ALL] = s[mmc_pkg::SETUP_BIT_IMPERFECT_ALL];
		e[mmc_pkg::BIT_INVERSE_FILTER] = s[mmc_pkg::SETUP_BIT_INVERSE];
		return e;
	endfunction : exp_mode

	function automatic logic exp_acc(input logic [31:0] m, input logic [2:0] s,
		input logic mc, input logic bad, input logic ph, input logic hh);
		logic hit;
		// Hash-only filtering is a sub-mode of hash filtering; perfect mode ignores it.
		if (s[mmc_pkg::SETUP_BIT_HASH_PERFECT] && (mc || s[mmc_pkg::SETUP_BIT_IMPERFECT_ALL])) begin
			hit = hh;
		end else if (s[mmc_pkg::SETUP_BIT_HASH_PERFECT]) begin
			hit = ph;
		end else begin
			hit = ph ^ s[mmc_pkg::SETUP_BIT_INVERSE];
		end
		hit = hit | m[mmc_pkg::BIT_ACCEPT_ALL] | (mc & m[mmc_pkg::BIT_PASS_ALL_MULTICAST]);
		return hit & (~bad | m[mmc_pkg::BIT_PASS_BAD]);
	endfunction : exp_acc

	task automatic rx_frame(input logic mc, input logic bad, input logic ph, input logic hh,
		input logic expd);
		logic [47:0] a;
		a = 48'({$urandom(), $urandom()});
		a[40] = mc;
		@(posedge sys_clk);
		rxDestAddr <= a;
		rxFrameBad <= bad;
		perfectHit <= ph;
		hashHit <= hh;
		rxFrameDone <= 1'h1;
		@(posedge sys_clk);
		rxFrameDone <= 1'h0;
		for (int i = 0; i < 6 && rxAcceptValid !== 1'h1; i++) begin
			@(posedge sys_clk);
			#1;
		end
		chk_bit(rxAcceptValid, 1'h1);
		chk_bit(rxAccept, expd);
	endtask : rx_frame

	// Counts attempts; a collision is injected at the second cycle of each early attempt.
	task automatic run_tx(input int okAfter, input int colls, output int att, output logic exc);
		int hi;
		int nc;
		logic doOk;
		logic doColl;
		att = 0;
		hi = 0;
		nc = 0;
		doOk = 1'h0;
		doColl = 1'h0;
		exc = 1'h0;
		@(posedge sys_clk);
		txRequest <= 1'h1;
		@(posedge sys_clk);
		txRequest <= 1'h0;
		for (int i = 0; i < 3000; i++) begin
			@(posedge sys_clk);
			txEndOk <= doOk;
			collisionIn <= doColl;
			#1;
			if (txDone === 1'h1) begin
				exc = txExcessiveCollision;
				break;
			end
			hi = (txEnable === 1'h1) ? hi + 1 : 0;
			if (hi == 1) att++;
			doColl = (hi == 1) && (nc < colls);
			if (doColl) nc++;
			doOk = (hi == okAfter) && !doColl;
		end
		chk_bit(txDone, 1'h1);
		txEndOk <= 1'h0;
		collisionIn <= 1'h0;
	endtask : run_tx

	initial begin
		repeat (40000) @(posedge sys_clk);
		err_total++;
		end_sim();
	end

	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial begin
		logic [31:0] rdv;
		logic [31:0] w;
		logic [2:0] setup;
		logic mc, bad, ph, hh;
		logic exc;
		int att;
		int n;
		int gap;
		void'($urandom(32'hD6E8));
		repeat (5) @(posedge sys_clk);
		reset <= 1'h0;
		rd(mmc_pkg::ADDR_MODE_CONTROL, rdv);
		chk_reg(rdv, mmc_pkg::MODE_CONTROL_RESET);
		chk_bit(heartbeatCheckEnable, 1'h1);
		rx_frame(1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
		rx_frame(1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
		wr(4'hF, $urandom);
		rd(4'hF, rdv);
		chk_reg(rdv, 32'h0);
		for (int i = 0; i < 8; i++) begin
			setup = 3'(i);
			w = $urandom & 32'hFFFF_CEFD;
			if (w[mmc_pkg::BIT_FULL_DUPLEX]) begin
				w[mmc_pkg::BIT_LOOPBACK_LO] = 1'h0;
			end
			wr(mmc_pkg::ADDR_FILTER_SETUP, {29'h0, setup});
			wr(mmc_pkg::ADDR_MODE_CONTROL, w);
			rd(mmc_pkg::ADDR_MODE_CONTROL, rdv);
			chk_reg(rdv, exp_mode(w, setup));
			chk_bit(fullDuplex, w[mmc_pkg::BIT_FULL_DUPLEX]);
			chk_bit(heartbeatCheckEnable, ~w[mmc_pkg::BIT_FULL_DUPLEX]);
			for (int j = 0; j < 8; j++) begin
				{mc, bad, ph, hh} = 4'($urandom);
				rx_frame(mc, bad, ph, hh, exp_acc(w, setup, mc, bad, ph, hh));
			end
		end
		wr(mmc_pkg::ADDR_FILTER_SETUP, 32'h0);
		for (int k = 0; k < 3; k++) begin
			wr(mmc_pkg::ADDR_MODE_CONTROL, 32'(k) << mmc_pkg::BIT_LOOPBACK_LO);
			@(posedge sys_clk);
			#1;
			chk_reg({30'h0, loopbackSelect}, 32'(k));
		end
		wr(mmc_pkg::ADDR_MODE_CONTROL, (32'(mmc_pkg::LOOP_INTERNAL) << 10) | 32'h1000);
		run_tx(1000, 0, att, exc);
		chk_cnt(att, mmc_pkg::ATTEMPT_LIMIT, mmc_pkg::ATTEMPT_LIMIT);
		chk_bit(exc, 1'h1);
		wr(mmc_pkg::ADDR_MODE_CONTROL, (32'(mmc_pkg::LOOP_EXTERNAL) << 10) | 32'h1000);
		run_tx(3, 0, att, exc);
		chk_cnt(att, 1, 1);
		chk_bit(exc, 1'h0);
		chk_cnt(nForced, mmc_pkg::ATTEMPT_LIMIT, mmc_pkg::ATTEMPT_LIMIT);
		wr(mmc_pkg::ADDR_MODE_CONTROL, 32'h0);
		run_tx(3, 2, att, exc);
		chk_cnt(att, 3, 3);
		carrierSense <= 1'h1;
		run_tx(3, 1, att, exc);
		chk_cnt(att, 2, 2);
		carrierSense <= 1'h0;
		wr(mmc_pkg::ADDR_MODE_CONTROL, 32'h1 << mmc_pkg::BIT_FULL_DUPLEX);
		rxActive <= 1'h1;
		run_tx(3, 0, att, exc);
		rxActive <= 1'h0;
		chk_cnt(att, 1, 1);
		chk_bit(heartbeatCheckEnable, 1'h0);
		// Both rates: the transmitter must stay quiet for the full gap after carrier.
		for (int r = 0; r < 2; r++) begin
			wr(mmc_pkg::ADDR_MODE_CONTROL, 32'h1 << mmc_pkg::BIT_BACKOFF_HOLD);
			rate100 <= r[0];
			carrierSense <= 1'h1;
			@(posedge sys_clk);
			txRequest <= 1'h1;
			@(posedge sys_clk);
			txRequest <= 1'h0;
			repeat (20) @(posedge sys_clk);
			#1;
			chk_bit(txEnable, 1'h0);
			@(posedge sys_clk);
			carrierSense <= 1'h0;
			n = 0;
			for (int i = 0; i < 700 && txEnable !== 1'h1; i++) begin
				@(posedge sys_clk);
				#1;
				n++;
			end
			gap = (r == 1 ? mmc_pkg::GAP_100M_NS : mmc_pkg::GAP_10M_NS) / 20;
			chk_cnt(n, gap, gap + 40);
			@(posedge sys_clk);
			txEndOk <= 1'h1;
			@(posedge sys_clk);
			txEndOk <= 1'h0;
			repeat (3) @(posedge sys_clk);
		end
		end_sim();
	end
endmodule : mmc_mode_control_tb
`default_nettype wire
